// ### design/timer_counter_status_irq.sv
// two-channel timer: prescaled modulo counter, overflow/channel flags, irqs, APB regs
// assumes pclk is the bus clock; stop/break inputs come from logic on pclk,
// channel pins come from outside and are synchronised here
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "timer_regs.svh"

// Functional notes
// - counter equal to modulo sets overflow flag and restarts from zero next tick
// - overflow flag clears by read-seen-set then write zero; new overflow blocks it
// - overflow irq when overflow flag and its enable are set; enable resets low
// - halt bit freezes counter; reset sets halt
// - halt suppresses input captures
// - clear bit zeros counter and prescaler, self clears, reads zero
// - halt and clear in one write leave counter stopped at zero
// - prescale select divides by 1 to 64; code seven unused; resets to zero
// - high byte read latches low byte until low byte read
// - counter registers clear on reset and on clear bit
// - modulo high write blocks overflow flag until modulo low written
// - modulo registers reset to all ones
// - channel flag set on active pin edge or compare match
// - channel flag clears by read-seen-set then write zero; new event blocks it
// - channel irq when channel flag and enable set; enable resets low
// - in wait mode counting and flagging continue; irqs can wake cpu
// - stop mode freezes timer but keeps all state
// - break freezes counter and suppresses captures
// - break without permit keeps flags and pending first clear step
// - break with permit lets flags clear; they stay cleared
// - prescaler fed only from bus clock, no external clock pin
module timer_counter_status_irq
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_permit,
    input wire logic channel0_pin,
    input wire logic channel1_pin,
    output logic overflow_irq,
    output logic [1:0] channel_irq
);

    // status/control state
    logic halt_q;
    logic ovf_ie_q;
    logic [2:0] ps_q;
    logic ovf_flag_q;
    logic ovf_arm_q;
    presc_t pre_q;
    count_t cnt_q;
    count_t mod_q;
    logic mod_hold_q;
    logic latched_q;
    logic [7:0] lo_buf_q;
    logic [7:0] snap_lo_q;
    logic [7:0] rd_q;

    // channel state
    logic [1:0] ch_flag_q;
    logic [1:0] ch_arm_q;
    logic [1:0] ch_ie_q;
    logic [1:0] ch_cmp_q;
    edge_sel_e ch_edge_q [2];
    count_t ch_val_q [2];
    logic [1:0] ch_hold_q;
    logic [2:0] sync_q [2];
    logic [1:0] pin_lvl_q;

    // bus decode and events
    logic setup, wr_acc, rd_acc, hit, permit;
    logic wr_stat, rd_stat, clr_wr, run, tick, ovf_evt;
    logic [1:0] sc_wr, sc_rd, hi_wr, hi_rd, lo_wr, lo_rd, cap_evt, cmp_evt;
    logic [7:0] rd_data;

    // prescaler tap: true on the last count of the selected division
    function automatic logic tick_due(presc_t p, logic [2:0] s);
        presc_t m;
        m = 7'((8'h01 << s) - 8'h01);
        return (s != `PS_UNUSED) && ((p & m) == m);
    endfunction

    function automatic logic [7:0] ch_addr(int c, logic [7:0] ofs);
        return 8'(`OFS_CH0_BASE + 8'(c) * `CH_STRIDE + ofs);
    endfunction

    // apb strobes; zero wait states, every access completes at once
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    assign rd_acc = psel && penable && !pwrite;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = {24'h000000, rd_q};
    // reads and writes may only touch flags outside break or with permission
    assign permit = !break_active || break_clear_permit;

    // address decode for the fixed registers
    assign wr_stat = wr_acc && paddr == `OFS_STATUS;
    assign rd_stat = rd_acc && paddr == `OFS_STATUS;
    assign clr_wr = wr_stat && pwdata[`ST_CLR];

    // address decode for the channel registers
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sc_wr[c] = wr_acc && paddr == ch_addr(c, `CH_OFS_SC);
            sc_rd[c] = rd_acc && paddr == ch_addr(c, `CH_OFS_SC);
            hi_wr[c] = wr_acc && paddr == ch_addr(c, `CH_OFS_HI);
            hi_rd[c] = rd_acc && paddr == ch_addr(c, `CH_OFS_HI);
            lo_wr[c] = wr_acc && paddr == ch_addr(c, `CH_OFS_LO);
            lo_rd[c] = rd_acc && paddr == ch_addr(c, `CH_OFS_LO);
        end
    end

    // read mux, sampled in the setup cycle; unmapped reads give zero
    always_comb begin
        hit = 1'b1;
        rd_data = 8'h00;
        if (paddr == `OFS_STATUS) begin
            rd_data = {ovf_flag_q, ovf_ie_q, halt_q, 2'b00, ps_q};
        end else if (paddr == `OFS_CNT_HI) begin
            rd_data = cnt_q[15:8];
        end else if (paddr == `OFS_CNT_LO) begin
            rd_data = latched_q ? lo_buf_q : cnt_q[7:0];
        end else if (paddr == `OFS_MOD_HI) begin
            rd_data = mod_q[15:8];
        end else if (paddr == `OFS_MOD_LO) begin
            rd_data = mod_q[7:0];
        end else if (paddr == ch_addr(0, `CH_OFS_SC)) begin
            rd_data = {ch_flag_q[0], ch_ie_q[0], 1'b0, ch_cmp_q[0], ch_edge_q[0], 2'b00};
        end else if (paddr == ch_addr(0, `CH_OFS_HI)) begin
            rd_data = ch_val_q[0][15:8];
        end else if (paddr == ch_addr(0, `CH_OFS_LO)) begin
            rd_data = ch_val_q[0][7:0];
        end else if (paddr == ch_addr(1, `CH_OFS_SC)) begin
            rd_data = {ch_flag_q[1], ch_ie_q[1], 1'b0, ch_cmp_q[1], ch_edge_q[1], 2'b00};
        end else if (paddr == ch_addr(1, `CH_OFS_HI)) begin
            rd_data = ch_val_q[1][15:8];
        end else if (paddr == ch_addr(1, `CH_OFS_LO)) begin
            rd_data = ch_val_q[1][7:0];
        end else begin
            hit = 1'b0;
        end
    end

    // read data and low-byte snapshot are taken together so a latch never skews
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= 8'h00;
            snap_lo_q <= 8'h00;
        end else if (setup) begin
            rd_q <= pwrite ? 8'h00 : rd_data;
            snap_lo_q <= cnt_q[7:0];
        end
    end

    // control fields of the status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= `RST_HALT;
            ovf_ie_q <= 1'b0;
            ps_q <= `RST_PS;
        end else if (wr_stat) begin
            halt_q <= pwdata[`ST_HALT];
            ovf_ie_q <= pwdata[`ST_IE];
            ps_q <= pwdata[`ST_PS_HI:`ST_PS_LO];
        end
    end

    // runs only from pclk; stop, break and halt all freeze it
    assign run = !halt_q && !stop_mode && !break_active;
    assign tick = run && tick_due(pre_q, ps_q);
    assign ovf_evt = tick && cnt_q == mod_q && !mod_hold_q && !clr_wr;

    // prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 7'h00;
        end else if (clr_wr) begin
            pre_q <= 7'h00;
        end else if (run) begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // 16-bit modulo up-counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `RST_CNT;
        end else if (clr_wr) begin
            cnt_q <= `RST_CNT;
        end else if (tick) begin
            cnt_q <= (cnt_q == mod_q) ? `RST_CNT : cnt_q + 16'h0001;
        end
    end

    // modulo registers; a high-byte write holds off overflow until the low byte lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_q <= `RST_MOD;
            mod_hold_q <= 1'b0;
        end else if (wr_acc && paddr == `OFS_MOD_HI) begin
            mod_q[15:8] <= pwdata[7:0];
            mod_hold_q <= 1'b1;
        end else if (wr_acc && paddr == `OFS_MOD_LO) begin
            mod_q[7:0] <= pwdata[7:0];
            mod_hold_q <= 1'b0;
        end
    end

    // overflow flag; a new overflow wins over a clearing write and disarms it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_q <= 1'b0;
            ovf_arm_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag_q <= 1'b1;
            ovf_arm_q <= 1'b0;
        end else if (wr_stat && !pwdata[`ST_FLAG] && ovf_arm_q && permit) begin
            ovf_flag_q <= 1'b0;
            ovf_arm_q <= 1'b0;
        end else if (rd_stat && rd_q[`ST_FLAG] && permit) begin
            ovf_arm_q <= 1'b1;
        end
    end

    // low-byte latch; a clear drops it since the counter restarts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_q <= 1'b0;
            lo_buf_q <= 8'h00;
        end else if (clr_wr) begin
            latched_q <= 1'b0;
            lo_buf_q <= 8'h00;
        end else if (rd_acc && paddr == `OFS_CNT_HI && !latched_q) begin
            latched_q <= 1'b1;
            lo_buf_q <= snap_lo_q;
        end else if (rd_acc && paddr == `OFS_CNT_LO) begin
            latched_q <= 1'b0;
        end
    end

    // three-stage pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q[0] <= 3'h0;
            sync_q[1] <= 3'h0;
            pin_lvl_q <= 2'b00;
        end else begin
            sync_q[0] <= {sync_q[0][1:0], channel0_pin};
            sync_q[1] <= {sync_q[1][1:0], channel1_pin};
            for (int c = 0; c < 2; c++) begin
                if (sync_q[c][1] == sync_q[c][2]) begin
                    pin_lvl_q[c] <= sync_q[c][2];
                end
            end
        end
    end

    // capture and compare events; captures need a running timer
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cap_evt[c] = !ch_cmp_q[c] && !ch_hold_q[c] && run
                && (sync_q[c][1] == sync_q[c][2]) && (sync_q[c][2] != pin_lvl_q[c])
                && (sync_q[c][2] ? ch_edge_q[c][0] : ch_edge_q[c][1]);
            cmp_evt[c] = ch_cmp_q[c] && !ch_hold_q[c] && tick
                && cnt_q == ch_val_q[c];
        end
    end

    // channel control, values and two-step flag clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_flag_q <= 2'b00;
            ch_arm_q <= 2'b00;
            ch_ie_q <= 2'b00;
            ch_cmp_q <= 2'b00;
            ch_hold_q <= 2'b00;
            for (int c = 0; c < 2; c++) begin
                ch_edge_q[c] <= edge_none;
                ch_val_q[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (sc_wr[c]) begin
                    ch_ie_q[c] <= pwdata[`CH_IE];
                    ch_cmp_q[c] <= pwdata[`CH_CMP];
                    ch_edge_q[c] <= edge_sel_e'(pwdata[`CH_EDGE_HI:`CH_EDGE_LO]);
                end
                if (cap_evt[c] || cmp_evt[c]) begin
                    ch_flag_q[c] <= 1'b1;
                    ch_arm_q[c] <= 1'b0;
                end else if (sc_wr[c] && !pwdata[`CH_FLAG] && ch_arm_q[c] && permit) begin
                    ch_flag_q[c] <= 1'b0;
                    ch_arm_q[c] <= 1'b0;
                end else if (sc_rd[c] && rd_q[`CH_FLAG] && permit) begin
                    ch_arm_q[c] <= 1'b1;
                end
                if (cap_evt[c]) begin
                    ch_val_q[c] <= cnt_q;
                end else if (hi_wr[c]) begin
                    ch_val_q[c][15:8] <= pwdata[7:0];
                end else if (lo_wr[c]) begin
                    ch_val_q[c][7:0] <= pwdata[7:0];
                end
                // high-byte write, or high-byte read in capture mode, holds off events until its low byte partner
                if (hi_wr[c] || (hi_rd[c] && !ch_cmp_q[c])) begin
                    ch_hold_q[c] <= 1'b1;
                end else if (lo_wr[c] || lo_rd[c]) begin
                    ch_hold_q[c] <= 1'b0;
                end
            end
        end
    end

    // interrupt requests; level, held while flag and enable stay set
    assign overflow_irq = ovf_flag_q && ovf_ie_q;
    assign channel_irq = ch_flag_q & ch_ie_q;

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        ovf_evt |=> ovf_flag_q && cnt_q == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow did not flag or wrap");

    property p_ovf_keep;
        @(posedge pclk) disable iff (!presetn)
        ovf_flag_q && wr_stat && !ovf_arm_q |=> ovf_flag_q;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("flag cleared unarmed");

    property p_ovf_irq;
        @(posedge pclk) disable iff (!presetn)
        ovf_evt && ovf_ie_q && !wr_stat |=> overflow_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        halt_q && !clr_wr |=> $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted");

    property p_halt_cap;
        @(posedge pclk) disable iff (!presetn)
        halt_q && !ch_flag_q[0] |=> !ch_flag_q[0];
    endproperty
    a_halt_cap: assert property (p_halt_cap) else $error("event while halted");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        clr_wr |=> cnt_q == 16'h0000 && pre_q == 7'h00 && !rd_q[`ST_CLR];
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero counter");

    property p_halt_clear;
        @(posedge pclk) disable iff (!presetn)
        clr_wr && pwdata[`ST_HALT] |=> (cnt_q == 16'h0000)[*2];
    endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("not stopped at zero");

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        latched_q && !(rd_acc && paddr == `OFS_CNT_LO) && !clr_wr |=> $stable(lo_buf_q);
    endproperty
    a_latch: assert property (p_latch) else $error("latched low byte changed");

    property p_mod_hold;
        @(posedge pclk) disable iff (!presetn)
        mod_hold_q && !ovf_flag_q |=> !ovf_flag_q;
    endproperty
    a_mod_hold: assert property (p_mod_hold) else $error("overflow during hold");

    // a channel 1 compare hit with the enable set must show on its request line one edge later
    property p_ch_irq;
        @(posedge pclk) disable iff (!presetn)
        cmp_evt[1] && ch_ie_q[1] && !sc_wr[1] |=> channel_irq[1];
    endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("channel irq missing");

    property p_brk;
        @(posedge pclk) disable iff (!presetn)
        break_active && !clr_wr |=> $stable(cnt_q);
    endproperty
    a_brk: assert property (p_brk) else $error("counter moved in break");

    property p_brk_flag;
        @(posedge pclk) disable iff (!presetn)
        break_active && !break_clear_permit && ovf_flag_q |=> ovf_flag_q;
    endproperty
    a_brk_flag: assert property (p_brk_flag) else $error("flag cleared in break");

endmodule

// ### design/timer_pkg.sv
// shared types of the timer counter block
// assumes timer_regs.svh carries all numeric constants
package timer_pkg;
    typedef logic [15:0] count_t;
    typedef logic [6:0] presc_t;
    typedef enum logic [1:0] {
        edge_none = 2'b00,
        edge_rise = 2'b01,
        edge_fall = 2'b10,
        edge_any = 2'b11
    } edge_sel_e;
endpackage

// ### design/timer_regs.svh
// register map, field positions and reset values for the timer block
// assumes an APB slave with byte addresses and the low byte of pwdata carrying data
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// byte offsets, one aligned word per register
`define OFS_STATUS 8'h00
`define OFS_CNT_HI 8'h04
`define OFS_CNT_LO 8'h08
`define OFS_MOD_HI 8'h0c
`define OFS_MOD_LO 8'h10
`define OFS_CH0_BASE 8'h14
`define CH_STRIDE 8'h0c
`define CH_OFS_SC 8'h00
`define CH_OFS_HI 8'h04
`define CH_OFS_LO 8'h08

// status/control fields
`define ST_FLAG 7
`define ST_IE 6
`define ST_HALT 5
`define ST_CLR 4
`define ST_PS_HI 2
`define ST_PS_LO 0

// channel status/control fields
`define CH_FLAG 7
`define CH_IE 6
`define CH_CMP 4
`define CH_EDGE_HI 3
`define CH_EDGE_LO 2

// reset values and the unused prescale code
`define RST_HALT 1'b1
`define RST_PS 3'h0
`define RST_MOD 16'hffff
`define RST_CNT 16'h0000
`define PS_UNUSED 3'h7

`endif

// ### sim/cpu_model.sv
// apb master standing in for the cpu core, one transfer at a time
// assumes a single pclk domain; the testbench calls xfer hierarchically
`timescale 1ns/1ps
module cpu_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic hung = 1'b0;

    // idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    // setup, then access held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        hung = hung | (n >= 20);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data toggles so a stale word never passes for a fresh one
        pwdata <= ~pwdata;
        pstrb <= 4'h0;
    endtask
endmodule

// ### sim/testbench.sv
// self-checking bench: register table, prescaled counting, flags, freezes, channels
// assumes cpu_model speaks apb and the timer answers with zero wait states
`timescale 1ns/1ps
`include "timer_regs.svh"
module testbench import timer_pkg::*;;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic err;} row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, overflow_irq, e;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic stop_mode = 1'b0, break_active = 1'b0, break_clear_permit = 1'b0;
    logic channel0_pin = 1'b0, channel1_pin = 1'b0;
    logic [1:0] channel_irq;
    logic [2:0] irqs;
    int error_cnt = 0, checks = 0, n;
    count_t v;
    // reads carry expected data, writes carry write data
    row_s rows [13] = '{'{1'b0, `OFS_STATUS, 8'h20, 1'b0}, '{1'b0, `OFS_CNT_HI, 8'h00, 1'b0},
        '{1'b0, `OFS_CNT_LO, 8'h00, 1'b0}, '{1'b0, `OFS_MOD_HI, 8'hff, 1'b0},
        '{1'b0, `OFS_MOD_LO, 8'hff, 1'b0}, '{1'b0, 8'h14, 8'h00, 1'b0},
        '{1'b0, 8'h20, 8'h00, 1'b0}, '{1'b1, `OFS_STATUS, 8'h37, 1'b0},
        '{1'b0, `OFS_STATUS, 8'h27, 1'b0}, '{1'b0, 8'h2c, 8'h00, 1'b1},
        '{1'b1, 8'h2c, 8'h55, 1'b1}, '{1'b1, `OFS_MOD_HI, 8'h12, 1'b0},
        '{1'b0, `OFS_MOD_HI, 8'h12, 1'b0}};

    assign irqs = {overflow_irq, channel_irq};

    // 40 MHz bus clock
    always #12.5 pclk = ~pclk;

    timer_counter_status_irq u_timer_counter_status_irq (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_permit(break_clear_permit), .channel0_pin(channel0_pin),
        .channel1_pin(channel1_pin), .overflow_irq(overflow_irq), .channel_irq(channel_irq));

    cpu_model u_cpu_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one bus transfer; a hung bus ends the run
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        u_cpu_model.xfer(w, a, d, q, e);
        if (u_cpu_model.hung) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk(16'(q), 16'(x));
    endtask

    // high byte first so the low byte comes from the latch
    task automatic rdcnt();
        bus(1'b0, `OFS_CNT_HI, 8'h00);
        v[15:8] = q;
        bus(1'b0, `OFS_CNT_LO, 8'h00);
        v[7:0] = q;
    endtask

    // let the edge's updates land before looking at a level
    task automatic ichk(input int i, input logic x);
        #1;
        chk(16'(irqs[i]), 16'(x));
    endtask

    // bounded wait for an interrupt line; n holds the edges it took
    task automatic wait_irq(input int i, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (irqs[i] !== 1'b1 && n < lim);
        if (n >= lim) begin
            error_cnt++;
            close_out();
        end
    endtask

    // clear and run with overflow irq enabled until the flag sets
    task automatic ovf();
        wr(`OFS_STATUS, 8'h70);
        wr(`OFS_STATUS, 8'h40);
        wait_irq(2, 40);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(16'(q), 16'(rows[i].d));
            chk(16'(e), 16'(rows[i].err));
        end
        wr(`OFS_MOD_LO, 8'h34);
        // a 128-edge run window holds exactly 128 >> ps ticks for ps 0 to 6 and none for ps 7, whatever the phase
        for (int ps = 0; ps < 8; ps++) begin
            wr(`OFS_STATUS, 8'h30);
            wr(`OFS_STATUS, 8'(ps));
            repeat (125) @(posedge pclk);
            wr(`OFS_STATUS, 8'h20 | 8'(ps));
            rdcnt();
            chk(v, ps == 7 ? 16'h0 : 16'd128 >> ps);
        end
        wr(`OFS_STATUS, 8'h00);
        repeat (9) @(posedge pclk);
        wr(`OFS_STATUS, 8'h30);
        repeat (20) @(posedge pclk);
        rdcnt();
        chk(v, 16'h0);
        wr(`OFS_STATUS, 8'h00);
        wr(`OFS_STATUS, 8'h20);
        rd(`OFS_CNT_HI, 8'h00);
        wr(`OFS_STATUS, 8'h00);
        repeat (5) @(posedge pclk);
        wr(`OFS_STATUS, 8'h20);
        rd(`OFS_CNT_HI, 8'h00);
        rd(`OFS_CNT_LO, 8'h03);
        rdcnt();
        chk(v, 16'h000b);
        wr(`OFS_MOD_HI, 8'h00);
        wr(`OFS_MOD_LO, 8'h10);
        ovf();
        chk(16'(n), 16'd17);
        rd(`OFS_STATUS, 8'hc0);
        repeat (20) @(posedge pclk);
        wr(`OFS_STATUS, 8'he0);
        wr(`OFS_STATUS, 8'h60);
        wr(`OFS_STATUS, 8'ha0);
        ichk(2, 1'b0);
        wr(`OFS_STATUS, 8'he0);
        ichk(2, 1'b1);
        rd(`OFS_STATUS, 8'he0);
        wr(`OFS_STATUS, 8'h60);
        rd(`OFS_STATUS, 8'h60);
        ichk(2, 1'b0);
        wr(`OFS_STATUS, 8'h70);
        wr(`OFS_MOD_HI, 8'h00);
        wr(`OFS_STATUS, 8'h40);
        repeat (40) @(posedge pclk);
        ichk(2, 1'b0);
        wr(`OFS_MOD_LO, 8'h10);
        ovf();
        wr(`OFS_STATUS, 8'he0);
        rd(`OFS_STATUS, 8'he0);
        @(posedge pclk) break_active <= 1'b1;
        wr(`OFS_STATUS, 8'h60);
        rd(`OFS_STATUS, 8'he0);
        @(posedge pclk) break_active <= 1'b0;
        wr(`OFS_STATUS, 8'h60);
        rd(`OFS_STATUS, 8'h60);
        ovf();
        wr(`OFS_STATUS, 8'he0);
        @(posedge pclk) break_active <= 1'b1;
        break_clear_permit <= 1'b1;
        rd(`OFS_STATUS, 8'he0);
        wr(`OFS_STATUS, 8'h60);
        @(posedge pclk) break_active <= 1'b0;
        rd(`OFS_STATUS, 8'h60);
        // break then stop: one tick lands at the freezing edge, none after
        for (int k = 0; k < 2; k++) begin
            wr(`OFS_STATUS, 8'h30);
            wr(`OFS_STATUS, 8'h00);
            @(posedge pclk) stop_mode <= (k == 1);
            break_active <= (k == 0);
            repeat (20) @(posedge pclk);
            rdcnt();
            chk(v, 16'h0001);
            @(posedge pclk) stop_mode <= 1'b0;
            break_active <= 1'b0;
        end
        wr(8'h14, 8'h44);
        @(posedge pclk) channel0_pin <= 1'b1;
        wait_irq(0, 10);
        rd(8'h14, 8'hc4);
        wr(8'h14, 8'h44);
        rd(8'h14, 8'h44);
        ichk(0, 1'b0);
        wr(`OFS_STATUS, 8'h20);
        @(posedge pclk) channel0_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        channel0_pin <= 1'b1;
        repeat (10) @(posedge pclk);
        ichk(0, 1'b0);
        // falling-edge capture while running, then halt again before compare setup
        wr(8'h14, 8'h48);
        wr(`OFS_STATUS, 8'h00);
        @(posedge pclk) channel0_pin <= 1'b0;
        wait_irq(0, 10);
        wr(`OFS_STATUS, 8'h20);
        // compare value must not exceed the modulo of 0x10 or it is never reached
        wr(8'h20, 8'h50);
        wr(8'h24, 8'h00);
        wr(8'h28, 8'h08);
        wr(`OFS_STATUS, 8'h30);
        wr(`OFS_STATUS, 8'h00);
        wait_irq(1, 60);
        chk(16'(n), 16'd9);
        chk(16'(channel1_pin), 16'h0);
        // mid-run reset brings back reset values and drops the pending request
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        ichk(1, 1'b0);
        rd(`OFS_STATUS, 8'h20);
        rd(`OFS_MOD_LO, 8'hff);
        close_out();
    end
endmodule
